// ### pmbus_ctrl_pkg.sv
package pmbus_ctrl_pkg;

	// Command codes that the host sends on the link.
	localparam logic [7:0] CODE_OPERATION     = 8'h01;
	localparam logic [7:0] CODE_ONOFF_CONFIG  = 8'h02;
	localparam logic [7:0] CODE_CLEAR_FAULTS  = 8'h03;
	localparam logic [7:0] CODE_STORE_ALL     = 8'h11;
	localparam logic [7:0] CODE_RESTORE_ALL   = 8'h12;
	localparam logic [7:0] CODE_TRIM          = 8'h22;
	localparam logic [7:0] CODE_MARGIN_HIGH   = 8'h25;
	localparam logic [7:0] CODE_MARGIN_LOW    = 8'h26;
	localparam logic [7:0] CODE_SCALE_LOOP    = 8'h29;
	localparam logic [7:0] CODE_OC_WARN       = 8'h4a;
	localparam logic [7:0] CODE_RISE_TIME     = 8'h61;
	localparam logic [7:0] CODE_STATUS_BYTE   = 8'h78;
	localparam logic [7:0] CODE_STATUS_THERM  = 8'h7d;
	localparam logic [7:0] CODE_STATUS_CML    = 8'h7e;

	// Field positions of the on/off policy byte, and of the enable bit in the operation byte.
	localparam int POS_POWERUP_POLICY = 4;
	localparam int POS_CMD_RESPONSE   = 3;
	localparam int POS_PIN_RESPONSE   = 2;
	localparam int POS_PIN_POLARITY   = 1;
	localparam int POS_OUTPUT_ENABLE  = 7;

	// Reset values, and the largest accepted ratio.
	localparam logic [4:0]  RESET_ONOFF_CONFIG = 5'h17;
	localparam logic [7:0]  RESET_OPERATION    = 8'h80;
	localparam logic [9:0]  RESET_SCALE        = 10'h100;
	localparam logic [9:0]  SCALE_MAX          = 10'h200;
	localparam logic [2:0]  RESET_RISE_SELECT  = 3'h0;
	localparam logic [15:0] RESET_MARGIN_HIGH  = 16'h0000;
	localparam logic [15:0] RESET_MARGIN_LOW   = 16'h0000;

	// Fixed exponents of the linear words.
	localparam logic [4:0] EXP_RISE  = 5'h1c;
	localparam logic [4:0] EXP_SCALE = 5'h17;
	localparam logic [4:0] EXP_OC    = 5'h1f;

	// Rise time settings, in microseconds and as mantissas of 2^-4 ms.
	localparam int RISE_TIME_US [8] = '{600, 900, 1200, 1800,
		2700, 4200, 6000, 9000};
	localparam logic [10:0] RISE_MANT [8] = '{11'h00a, 11'h00e, 11'h013,
		11'h01d, 11'h02b, 11'h043, 11'h060, 11'h090};

	// Reference voltage in units of 2^-19 V, and the +/-25% window.
	localparam longint VREF_MV      = 600;
	localparam longint VREF_NOM     = (VREF_MV * 524288 + 500) / 1000;
	localparam longint VREF_LOW     = (VREF_NOM * 3) / 4;
	localparam longint VREF_HIGH    = (VREF_NOM * 5) / 4;
	localparam longint TRIM_SPAN    = VREF_NOM / 4;

	// Margin field encodings.
	localparam logic [3:0] MARGIN_LOW_IGNORE  = 4'h5;
	localparam logic [3:0] MARGIN_LOW_ACT     = 4'h6;
	localparam logic [3:0] MARGIN_HIGH_IGNORE = 4'h9;
	localparam logic [3:0] MARGIN_HIGH_ACT    = 4'ha;

	// One command as handed over by the link transport.
	typedef struct packed {
		logic        write;
		logic [7:0]  code;
		logic [15:0] data;
		logic        pec_ok;
	} link_command_type;

endpackage

// ### pmbus_output_control.sv
`timescale 1ns/1ns

module pmbus_output_control
	import pmbus_ctrl_pkg::*;
#(
	parameter logic [4:0] OC_WARN_DEFAULT = 5'h0a
) (
	// Controller clock and reset.
	input  wire logic             clock,
	input  wire logic             reset,
	// Link side, on the host serial clock.
	input  wire logic             link_clock,
	input  wire logic             cmd_valid,
	input  wire link_command_type cmd,
	output logic                  cmd_ready,
	output logic                  rsp_valid,
	output logic [15:0]           rsp_data,
	// Board pins, asynchronous to the controller clock.
	input  wire logic             onoff_pin,
	input  wire logic             power_present,
	input  wire logic             overtemp_fault,
	input  wire logic             overtemp_warn,
	// Open-drain alert line.
	output logic                  alert_out,
	output logic                  alert_oe_n,
	// Regulation controls.
	output logic                  output_run,
	output logic [2:0]            rise_select,
	output logic [23:0]           vref_setting,
	output logic                  margin_act_on_fault,
	output logic [4:0]            oc_warn_limit
);

	typedef struct packed {
		logic             req_toggle;
		link_command_type held;
		logic [2:0]       ack_sync;
		logic [15:0]      rsp_data;
		logic             rsp_valid;
	} link_state_type;

	typedef struct packed {
		logic [7:0]  operation;
		logic [4:0]  onoff_config;
		logic [2:0]  rise_select;
		logic [9:0]  scale;
		logic [15:0] trim;
		logic [15:0] margin_high;
		logic [15:0] margin_low;
		logic [4:0]  oc_mant;
		logic [15:0] nv_margin_high;
		logic [15:0] nv_margin_low;
		logic [4:0]  nv_oc_mant;
		logic [1:0]  therm_status;
		logic        cml_command;
		logic        cml_data;
		logic        cml_pec;
		logic [2:0]  req_sync;
		logic [1:0]  pin_sync;
		logic [1:0]  power_sync;
		logic [1:0]  otf_sync;
		logic [1:0]  otw_sync;
		logic        ack_toggle;
		logic [15:0] rsp_data;
		logic [23:0] vref;
		logic        run;
	} core_state_type;

	link_state_type lnk;
	link_state_type next_lnk;
	core_state_type core;
	core_state_type next_core;

	// Picks the longest listed rise time not above the request, or the shortest if all are above it.
	function automatic logic [2:0] rise_index(input logic [10:0] mant);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (mant >= RISE_MANT[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	// Checks that trim times ratio stays within a quarter of nominal.
	function automatic logic trim_in_span(input logic [15:0] trim,
			input logic [9:0] scale);
		logic signed [31:0] prod;
		prod = 32'(signed'(trim)) * 32'(signed'({1'b0, scale}));
		return (prod <= 32'(TRIM_SPAN)) && (prod >= -32'(TRIM_SPAN));
	endfunction

	// Turns a margin mode field into low/high selection bits.
	function automatic logic [1:0] margin_mode(input logic [3:0] field);
		logic [1:0] mode;
		mode = 2'b00;
		if (field == MARGIN_LOW_IGNORE || field == MARGIN_LOW_ACT) begin
			mode = 2'b01;
		end else if (field == MARGIN_HIGH_IGNORE ||
				field == MARGIN_HIGH_ACT) begin
			mode = 2'b10;
		end
		return mode;
	endfunction

	// Link domain: latch a command, toggle a request, await the answer.
	always_comb begin
		next_lnk = lnk;
		next_lnk.rsp_valid = 1'b0;
		next_lnk.ack_sync = {lnk.ack_sync[1:0], core.ack_toggle};
		if (cmd_valid && cmd_ready) begin
			next_lnk.held = cmd;
			next_lnk.req_toggle = ~lnk.req_toggle;
		end
		if (lnk.ack_sync[2] != lnk.ack_sync[1]) begin
			next_lnk.rsp_data = core.rsp_data;
			next_lnk.rsp_valid = 1'b1;
		end
	end

	always_ff @(posedge link_clock or posedge reset) begin
		if (reset) begin
			lnk <= '0;
		end else begin
			lnk <= next_lnk;
		end
	end

	// Ready once the answer to the last request has come back.
	assign cmd_ready = (lnk.req_toggle == lnk.ack_sync[2]);
	assign rsp_valid = lnk.rsp_valid;
	assign rsp_data  = lnk.rsp_data;

	// Core domain: command decode, status, enable and reference logic.
	always_comb begin
		logic              req_edge;
		logic              pin_active;
		logic              pin_ok;
		logic              cmd_ok;
		logic [1:0]        mode;
		logic              trim_ok;
		logic signed [31:0] eff_trim;
		logic signed [31:0] target;
		logic [15:0]       wdata;
		logic              bad_data;
		logic              bad_code;
		req_edge   = core.req_sync[2] != core.req_sync[1];
		pin_active = core.pin_sync[1] ==
			core.onoff_config[POS_PIN_POLARITY];
		pin_ok     = 1'b0;
		cmd_ok     = 1'b0;
		mode       = margin_mode(core.operation[5:2]);
		trim_ok    = trim_in_span(core.trim, core.scale);
		eff_trim   = 32'sd0;
		target     = 32'sd0;
		wdata      = lnk.held.data;
		bad_data   = 1'b0;
		bad_code   = 1'b0;
		next_core  = core;

		// Pins pass two flip-flops before use.
		next_core.req_sync   = {core.req_sync[1:0], lnk.req_toggle};
		next_core.pin_sync   = {core.pin_sync[0], onoff_pin};
		next_core.power_sync = {core.power_sync[0], power_present};
		next_core.otf_sync   = {core.otf_sync[0], overtemp_fault};
		next_core.otw_sync   = {core.otw_sync[0], overtemp_warn};

		// Startup qualification from policy, pin and enable bit.
		pin_ok = !core.onoff_config[POS_PIN_RESPONSE] || pin_active;
		cmd_ok = !core.onoff_config[POS_CMD_RESPONSE] ||
			core.operation[POS_OUTPUT_ENABLE];
		if (!core.onoff_config[POS_POWERUP_POLICY]) begin
			next_core.run = core.power_sync[1];
		end else begin
			next_core.run = core.power_sync[1] && pin_ok && cmd_ok;
		end

		// Reference target; an out-of-span trim counts as zero.
		if (trim_ok) begin
			eff_trim = 32'(signed'(core.trim));
		end
		if (mode == 2'b01) begin
			target = (32'(signed'(core.margin_low)) + eff_trim) *
				32'(signed'({1'b0, core.scale}));
		end else if (mode == 2'b10) begin
			target = (32'(signed'(core.margin_high)) + eff_trim) *
				32'(signed'({1'b0, core.scale}));
		end else begin
			target = 32'(VREF_NOM) + eff_trim *
				32'(signed'({1'b0, core.scale}));
		end
		if (target < 32'(VREF_LOW)) begin
			target = 32'(VREF_LOW);
		end else if (target > 32'(VREF_HIGH)) begin
			target = 32'(VREF_HIGH);
		end
		next_core.vref = target[23:0];

		// Thermal flags are sticky; a new crossing wins over a clear.
		if (req_edge && lnk.held.pec_ok &&
				lnk.held.write && lnk.held.code == CODE_CLEAR_FAULTS) begin
			next_core.therm_status = 2'b00;
			next_core.cml_command = 1'b0;
			next_core.cml_data = 1'b0;
			next_core.cml_pec = 1'b0;
		end
		if (core.otf_sync[1]) begin
			next_core.therm_status[1] = 1'b1;
		end
		if (core.otw_sync[1]) begin
			next_core.therm_status[0] = 1'b1;
		end

		// One command per request toggle.
		if (req_edge) begin
			next_core.ack_toggle = ~core.ack_toggle;
			next_core.rsp_data = 16'h0000;
			if (!lnk.held.pec_ok) begin
				next_core.cml_pec = 1'b1;
			end else if (lnk.held.write) begin
				if (lnk.held.code == CODE_OPERATION) begin
					next_core.operation = wdata[7:0];
				end else if (lnk.held.code == CODE_ONOFF_CONFIG) begin
					next_core.onoff_config = {wdata[4:1], 1'b1};
				end else if (lnk.held.code == CODE_CLEAR_FAULTS) begin
					next_core.rsp_data = 16'h0000;
				end else if (lnk.held.code == CODE_STORE_ALL) begin
					next_core.nv_margin_high = core.margin_high;
					next_core.nv_margin_low = core.margin_low;
					next_core.nv_oc_mant = core.oc_mant;
				end else if (lnk.held.code == CODE_RESTORE_ALL) begin
					next_core.margin_high = core.nv_margin_high;
					next_core.margin_low = core.nv_margin_low;
					next_core.oc_mant = core.nv_oc_mant;
				end else if (lnk.held.code == CODE_TRIM) begin
					next_core.trim = wdata;
					if (!trim_in_span(wdata, core.scale)) begin
						bad_data = 1'b1;
					end
				end else if (lnk.held.code == CODE_MARGIN_HIGH) begin
					next_core.margin_high = {1'b0, wdata[14:0]};
				end else if (lnk.held.code == CODE_MARGIN_LOW) begin
					next_core.margin_low = {1'b0, wdata[14:0]};
				end else if (lnk.held.code == CODE_SCALE_LOOP) begin
					if (wdata[15:11] != EXP_SCALE || wdata[10] ||
							wdata[9:0] > SCALE_MAX) begin
						bad_data = 1'b1;
					end else begin
						next_core.scale = wdata[9:0];
					end
				end else if (lnk.held.code == CODE_OC_WARN) begin
					next_core.oc_mant = wdata[4:0];
				end else if (lnk.held.code == CODE_RISE_TIME) begin
					next_core.rise_select = rise_index(
						{2'b00, wdata[8:0]});
				end else begin
					bad_code = 1'b1;
				end
			end else begin
				if (lnk.held.code == CODE_OPERATION) begin
					next_core.rsp_data = {8'h00, core.operation};
				end else if (lnk.held.code == CODE_ONOFF_CONFIG) begin
					next_core.rsp_data = {11'h000, core.onoff_config};
				end else if (lnk.held.code == CODE_TRIM) begin
					next_core.rsp_data = core.trim;
				end else if (lnk.held.code == CODE_MARGIN_HIGH) begin
					next_core.rsp_data = core.margin_high;
				end else if (lnk.held.code == CODE_MARGIN_LOW) begin
					next_core.rsp_data = core.margin_low;
				end else if (lnk.held.code == CODE_SCALE_LOOP) begin
					next_core.rsp_data = {EXP_SCALE, 1'b0, core.scale};
				end else if (lnk.held.code == CODE_OC_WARN) begin
					next_core.rsp_data = {EXP_OC, 6'h00, core.oc_mant};
				end else if (lnk.held.code == CODE_RISE_TIME) begin
					next_core.rsp_data = {EXP_RISE,
						RISE_MANT[core.rise_select]};
				end else if (lnk.held.code == CODE_STATUS_THERM) begin
					next_core.rsp_data = {8'h00, core.therm_status,
						6'h00};
				end else if (lnk.held.code == CODE_STATUS_BYTE) begin
					next_core.rsp_data = {14'h0000, core.cml_command ||
						core.cml_data || core.cml_pec, 1'b0};
				end else if (lnk.held.code == CODE_STATUS_CML) begin
					next_core.rsp_data = {8'h00, core.cml_command,
						core.cml_data, core.cml_pec, 5'h00};
				end else begin
					bad_code = 1'b1;
				end
			end
			if (bad_data) begin
				next_core.cml_data = 1'b1;
			end
			if (bad_code) begin
				next_core.cml_command = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			core <= '0;
			core.operation <= RESET_OPERATION;
			core.onoff_config <= RESET_ONOFF_CONFIG;
			core.rise_select <= RESET_RISE_SELECT;
			core.scale <= RESET_SCALE;
			core.margin_high <= RESET_MARGIN_HIGH;
			core.margin_low <= RESET_MARGIN_LOW;
			core.nv_margin_high <= RESET_MARGIN_HIGH;
			core.nv_margin_low <= RESET_MARGIN_LOW;
			core.oc_mant <= OC_WARN_DEFAULT;
			core.nv_oc_mant <= OC_WARN_DEFAULT;
			core.vref <= VREF_NOM[23:0];
		end else begin
			core <= next_core;
		end
	end

	// Alert pulls the open-drain line low while any fault is pending.
	assign alert_out  = 1'b0;
	assign alert_oe_n = ~(core.cml_command || core.cml_data ||
		core.cml_pec || (|core.therm_status));

	assign output_run          = core.run;
	assign rise_select         = core.rise_select;
	assign vref_setting        = core.vref;
	assign margin_act_on_fault = core.operation[3] && !core.operation[2];
	assign oc_warn_limit       = core.oc_mant;

endmodule

// ### pmbus_output_control_chk.sv
`timescale 1ns/1ns
module pmbus_output_control_chk
	import pmbus_ctrl_pkg::*;
(
	// Clocks and reset.
	input wire logic        clock,
	input wire logic        reset,
	input wire logic        link_clock,
	// Link handshake.
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire logic        rsp_valid,
	input wire logic [15:0] rsp_data,
	// Controls.
	input wire logic        alert_out,
	input wire logic [2:0]  rise_select,
	input wire logic [23:0] vref_setting,
	input wire logic [4:0]  oc_warn_limit
);
	AST_TAKE: assert property (@(posedge link_clock) disable iff (reset)
		cmd_valid && cmd_ready |=> !cmd_ready)
		else $error("taken request left ready high");
	AST_ANSWER: assert property (@(posedge link_clock) disable iff (reset)
		cmd_valid && cmd_ready |=> ##[1:16] rsp_valid)
		else $error("no answer to a taken request");
	AST_PULSE: assert property (@(posedge link_clock) disable iff (reset)
		rsp_valid |=> !rsp_valid)
		else $error("answer pulse longer than one cycle");
	AST_READY: assert property (@(posedge link_clock) disable iff (reset)
		rsp_valid |-> cmd_ready && !$past(cmd_ready))
		else $error("answer without an outstanding request");
	AST_HOLD: assert property (@(posedge link_clock) disable iff (reset)
		!rsp_valid |-> $stable(rsp_data))
		else $error("answer word moved between answers");
	AST_WINDOW: assert property (@(posedge clock) disable iff (reset)
		vref_setting >= 24'(VREF_LOW) && vref_setting <= 24'(VREF_HIGH))
		else $error("reference outside the trim window");
	AST_BY_CMD: assert property (@(posedge clock) disable iff (reset)
		!$stable(vref_setting) || !$stable(rise_select)
		|| !$stable(oc_warn_limit) |-> !cmd_ready)
		else $error("setting moved with no command outstanding");
	AST_ALERT: assert property (@(posedge clock) disable iff (reset)
		alert_out == 1'b0)
		else $error("alert line driven high");
endmodule

bind pmbus_output_control pmbus_output_control_chk chk_i (.clock,
	.reset, .link_clock, .cmd_valid, .cmd_ready, .rsp_valid, .rsp_data,
	.alert_out, .rise_select, .vref_setting, .oc_warn_limit);

// ### pmbus_host_model.sv
`timescale 1ns/1ns
module pmbus_host_model
	import pmbus_ctrl_pkg::*;
(
	// Link transport.
	input  wire logic        link_clock,
	input  wire logic        cmd_ready,
	input  wire logic        rsp_valid,
	input  wire logic [15:0] rsp_data,
	output link_command_type cmd,
	output logic             cmd_valid
);
	// The link is idle at time zero.
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// Offers one command until taken, then collects its answer.
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [15:0] d, input logic pec, output logic [15:0] r);
		int n;
		n = 0;
		r = 'x;
		@(posedge link_clock);
		cmd_valid <= 1'b1;
		cmd <= '{write: w, code: c, data: d, pec_ok: pec};
		do begin
			@(posedge link_clock);
			n++;
		end while (cmd_ready !== 1'b1 && n < 50);
		// Released lines show the inverse, never the old command.
		cmd_valid <= 1'b0;
		cmd <= link_command_type'(~cmd);
		do begin
			@(posedge link_clock);
			n++;
		end while (rsp_valid !== 1'b1 && n < 150);
		if (rsp_valid === 1'b1) r = rsp_data;
	endtask
endmodule

// ### pmbus_output_control_tb_top.sv
`timescale 1ns/1ns
module pmbus_output_control_tb_top;
	import pmbus_ctrl_pkg::*;
	localparam logic [4:0] OC_DEF = 5'h0a;
	logic             clock = 1'b0;
	logic             link_clock = 1'b0;
	logic             reset = 1'b1;
	logic             onoff_pin = 1'b0;
	logic             power_present = 1'b1;
	logic             overtemp_fault = 1'b0;
	logic             overtemp_warn = 1'b0;
	logic             cmd_valid, cmd_ready, rsp_valid, alert_out;
	logic             alert_oe_n, output_run, margin_act_on_fault;
	link_command_type cmd;
	logic [15:0]      rsp_data;
	logic [2:0]       rise_select;
	logic [23:0]      vref_setting;
	logic [4:0]       oc_warn_limit;
	int               err_total = 0;
	int               num_checks = 0;

	// Controller clock at 8 ns.
	always #4 clock = ~clock;
	// Link clock at 15 ns, free running so answers can return.
	always begin
		#7 link_clock = 1'b1;
		#8 link_clock = 1'b0;
	end

	pmbus_output_control #(.OC_WARN_DEFAULT(OC_DEF)) dut (.clock, .reset,
		.link_clock, .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp_data,
		.onoff_pin, .power_present, .overtemp_fault, .overtemp_warn,
		.alert_out, .alert_oe_n, .output_run, .rise_select, .vref_setting,
		.margin_act_on_fault, .oc_warn_limit);
	pmbus_host_model host (.link_clock, .cmd_ready, .rsp_valid, .rsp_data,
		.cmd, .cmd_valid);

	// Compares a value with its expectation.
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Register write and checked read.
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		logic [15:0] r;
		host.xfer(1'b1, c, d, 1'b1, r);
	endtask
	task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
		logic [15:0] r;
		host.xfer(1'b0, c, 16'h0000, 1'b1, r);
		chk(r, exp);
	endtask
	task automatic settle;
		repeat (6) @(posedge clock);
	endtask

	// Reset values of the settings.
	task automatic test_reset;
		rchk(CODE_ONOFF_CONFIG, 16'h0017);
		rchk(CODE_OPERATION, 16'h0080);
		rchk(CODE_SCALE_LOOP, {EXP_SCALE, 11'h100});
		rchk(CODE_RISE_TIME, {EXP_RISE, RISE_MANT[0]});
		rchk(CODE_OC_WARN, {EXP_OC, 6'h00, OC_DEF});
		chk(vref_setting, 24'(VREF_NOM));
		chk(oc_warn_limit, OC_DEF);
		$display("test reset done");
	endtask

	// Pin, enable and policy combinations.
	task automatic test_onoff;
		logic [7:0] cf [4] = '{8'h02, 8'h1a, 8'h16, 8'h1e};
		logic e;
		for (int i = 0; i < 16; i++) begin
			wr(CODE_ONOFF_CONFIG, {8'h00, cf[i / 4]});
			wr(CODE_OPERATION, {8'h00, i[0], 7'h00});
			@(posedge clock) onoff_pin <= i[1];
			settle;
			e = !cf[i / 4][4] || ((!cf[i / 4][3] || i[0])
				&& (!cf[i / 4][2] || i[1]));
			chk(output_run, e);
		end
		@(posedge clock) power_present <= 1'b0;
		settle;
		chk(output_run, 1'b0);
		power_present <= 1'b1;
		wr(CODE_OPERATION, 16'h0080);
		$display("test onoff done");
	endtask

	// Every rise time setting, and a value between two of them.
	task automatic test_rise;
		for (int i = 0; i < 8; i++) begin
			wr(CODE_RISE_TIME, {EXP_RISE, RISE_MANT[i]});
			settle;
			chk(rise_select, i[2:0]);
			rchk(CODE_RISE_TIME, {EXP_RISE, RISE_MANT[i]});
		end
		wr(CODE_RISE_TIME, {EXP_RISE, RISE_MANT[3] + 11'h001});
		settle;
		chk(rise_select, 3'h3);
		$display("test rise done");
	endtask

	// Ratio at its maximum, one above it, then back to default.
	task automatic test_scale;
		wr(CODE_SCALE_LOOP, {EXP_SCALE, 11'h200});
		wr(CODE_SCALE_LOOP, {EXP_SCALE, 11'h201});
		rchk(CODE_SCALE_LOOP, {EXP_SCALE, 11'h200});
		rchk(CODE_STATUS_CML, 16'h0040);
		wr(CODE_CLEAR_FAULTS, 16'h0000);
		chk(vref_setting, 24'(VREF_NOM));
		wr(CODE_SCALE_LOOP, {EXP_SCALE, 11'h100});
		$display("test scale done");
	endtask

	// Fine, positive and negative trim, then one beyond the span.
	task automatic test_trim;
		logic [15:0] t [3] = '{16'h0001, 16'h0100, 16'hff00};
		logic [15:0] r;
		for (int i = 0; i < 3; i++) begin
			wr(CODE_TRIM, t[i]);
			settle;
			chk(vref_setting, 24'(VREF_NOM + 256 * $signed(t[i])));
		end
		wr(CODE_TRIM, 16'h0200);
		settle;
		chk(vref_setting, 24'(VREF_NOM));
		chk(alert_oe_n, 1'b0);
		host.xfer(1'b0, CODE_STATUS_BYTE, 16'h0000, 1'b1, r);
		chk(r[1], 1'b1);
		rchk(CODE_STATUS_CML, 16'h0040);
		wr(CODE_CLEAR_FAULTS, 16'h0000);
		settle;
		chk(alert_oe_n, 1'b1);
		$display("test trim done");
	endtask

	// Margin modes, clamping, store and restore.
	task automatic test_margin;
		logic [3:0] m [6] = '{4'h0, 4'h5, 4'h6, 4'h9, 4'ha, 4'hf};
		longint e [6] = '{0, 1168, 1168, 1296, 1296, 0};
		wr(CODE_MARGIN_HIGH, 16'h0500);
		wr(CODE_MARGIN_LOW, 16'h0480);
		wr(CODE_TRIM, 16'h0010);
		for (int i = 0; i < 6; i++) begin
			wr(CODE_OPERATION, {8'h00, 2'b10, m[i], 2'b00});
			settle;
			chk(vref_setting, 24'(e[i] ? e[i] * 256 : VREF_NOM + 4096));
			chk(margin_act_on_fault, m[i] == 4'h6 || m[i] == 4'ha);
		end
		wr(CODE_MARGIN_HIGH, 16'h0700);
		wr(CODE_OPERATION, 16'h00a4);
		settle;
		chk(vref_setting, 24'(VREF_HIGH));
		wr(CODE_MARGIN_LOW, 16'h0300);
		wr(CODE_OPERATION, 16'h0094);
		settle;
		chk(vref_setting, 24'(VREF_LOW));
		wr(CODE_MARGIN_HIGH, 16'h0500);
		wr(CODE_OC_WARN, {EXP_OC, 11'h00c});
		wr(CODE_STORE_ALL, 16'h0000);
		wr(CODE_MARGIN_HIGH, 16'h0600);
		wr(CODE_OC_WARN, {EXP_OC, 11'h003});
		wr(CODE_RESTORE_ALL, 16'h0000);
		rchk(CODE_MARGIN_HIGH, 16'h0500);
		rchk(CODE_OC_WARN, {EXP_OC, 11'h00c});
		chk(oc_warn_limit, 5'h0c);
		wr(CODE_OC_WARN, 16'hf8ff);
		rchk(CODE_OC_WARN, 16'hf81f);
		wr(CODE_OPERATION, 16'h0080);
		wr(CODE_TRIM, 16'h0000);
		$display("test margin done");
	endtask

	// Thermal flags, then refused and unknown commands.
	task automatic test_status;
		logic [15:0] r;
		for (int i = 0; i < 4; i++) begin
			@(posedge clock) {overtemp_fault, overtemp_warn} <= i[1:0];
			settle;
			wr(CODE_CLEAR_FAULTS, 16'h0000);
			rchk(CODE_STATUS_THERM, {8'h00, i[1:0], 6'h00});
		end
		host.xfer(1'b1, CODE_OPERATION, 16'h0000, 1'b0, r);
		chk(r, 16'h0000);
		rchk(CODE_OPERATION, 16'h0080);
		rchk(CODE_STATUS_CML, 16'h0020);
		wr(CODE_CLEAR_FAULTS, 16'h0000);
		rchk(8'h55, 16'h0000);
		rchk(CODE_STATUS_CML, 16'h0080);
		$display("test status done");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence.
	initial begin
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		test_reset;
		test_onoff;
		test_rise;
		test_scale;
		test_trim;
		test_margin;
		test_status;
		conclude;
	end
	// Watchdog against a hung handshake.
	initial begin
		repeat (60000) @(posedge clock);
		err_total++;
		conclude;
	end
endmodule
